// [shared/pmc_regs.vh]
// Timing counts, target addresses and serial register indexes for the proximity controller.
`ifndef PMC_REGS_VH
`define PMC_REGS_VH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define PMC_CLK_PERIOD_NS 40
`define PMC_PULSE_NS 7000
`define PMC_PULSE_CYC (`PMC_PULSE_NS / `PMC_CLK_PERIOD_NS)
`define PMC_WAIT_STEP_US 2700
`define PMC_WAIT_STEP_CYC (`PMC_WAIT_STEP_US * 1000 / `PMC_CLK_PERIOD_NS)
`define PMC_WAIT_LONG_MULT 12

// ----------------------------------------------------------------------
// Serial target addresses (selected by product variant strap)
// ----------------------------------------------------------------------
`define PMC_ADDR_MAIN 7'h39
`define PMC_ADDR_ALT 7'h29

// ----------------------------------------------------------------------
// Serial readable register indexes and command field
// ----------------------------------------------------------------------
`define PMC_IDX_STATUS 2'h0
`define PMC_IDX_DATA_LO 2'h1
`define PMC_IDX_DATA_HI 2'h2
`define PMC_IDX_PERSIST 2'h3
`define PMC_CMD_CLR_BIT 7
`define PMC_STAT_SAT_BIT 0
`define PMC_STAT_INT_BIT 1

`endif

// [verilog/pmc_i2c_target.v]
// Serial two-wire target port: address match, pointer write, interrupt clear, data reads.
`timescale 1ns/100ps
`include "pmc_regs.vh"

module pmc_i2c_target (
	// Clock, reset and enable.
	input wire mclk_i,
	input wire rst_b_i,
	input wire ce_i,
	// Bus pins as seen from outside the clock domain.
	input wire scl_i,
	input wire sda_i,
	output reg sda_oe_o,
	// Variant strap and readable state.
	input wire addr_alt_i,
	input wire [15:0] data_i,
	input wire sat_i,
	input wire int_i,
	input wire [3:0] persist_cnt_i,
	// One-cycle request to clear the interrupt.
	output reg clr_int_o
);

	localparam ST_IDLE = 3'd0;
	localparam ST_ADDR = 3'd1;
	localparam ST_ACK = 3'd2;
	localparam ST_WR = 3'd3;
	localparam ST_RD = 3'd4;
	localparam ST_RACK = 3'd5;

	reg [2:0] scl_s_reg; // Three-stage pin sampler for the serial clock.
	reg [2:0] sda_s_reg; // Three-stage pin sampler for the serial data.
	reg scl_f_reg; // Accepted clock level.
	reg sda_f_reg; // Accepted data level.
	reg scl_p_reg; // Accepted clock level one cycle earlier.
	reg sda_p_reg; // Accepted data level one cycle earlier.
	reg [2:0] state_reg; // Transfer state.
	reg [3:0] cnt_reg; // Bit counter within a byte.
	reg [7:0] sh_reg; // Receive shifter.
	reg [7:0] tx_reg; // Transmit shifter.
	reg [1:0] ptr_reg; // Register pointer, auto-incremented on reads.
	reg rw_reg; // Direction captured from the address byte.
	reg first_reg; // Next written byte is the pointer or command byte.
	reg nack_reg; // Controller declined further read bytes.
	reg [7:0] rd_byte; // Byte selected by the pointer.

	wire scl_rise = scl_f_reg & ~scl_p_reg;
	wire scl_fall = ~scl_f_reg & scl_p_reg;
	wire start_c = scl_f_reg & scl_p_reg & sda_p_reg & ~sda_f_reg;
	wire stop_c = scl_f_reg & scl_p_reg & ~sda_p_reg & sda_f_reg;
	wire [6:0] my_addr = addr_alt_i ? `PMC_ADDR_ALT : `PMC_ADDR_MAIN;

	// ----------------------------------------------------------------------
	// Read multiplexer
	// ----------------------------------------------------------------------
	// Readable bytes; status bits sit low, unused bits read as zero.
	always @* begin
		case (ptr_reg)
			`PMC_IDX_STATUS: rd_byte = {6'h00, int_i, sat_i};
			`PMC_IDX_DATA_LO: rd_byte = data_i[7:0];
			`PMC_IDX_DATA_HI: rd_byte = data_i[15:8];
			default: rd_byte = {4'h0, persist_cnt_i};
		endcase
	end

	// ----------------------------------------------------------------------
	// Pin sampling
	// ----------------------------------------------------------------------
	// A pin level is accepted only when the second and third stages agree,
	// which rejects glitches a single sample would let through.
	always @(posedge mclk_i) begin
		if (!rst_b_i) begin
			scl_s_reg <= 3'h7;
			sda_s_reg <= 3'h7;
			scl_f_reg <= 1'b1;
			sda_f_reg <= 1'b1;
			scl_p_reg <= 1'b1;
			sda_p_reg <= 1'b1;
		end else if (ce_i) begin
			scl_s_reg <= {scl_s_reg[1:0], scl_i};
			sda_s_reg <= {sda_s_reg[1:0], sda_i};
			if (scl_s_reg[1] == scl_s_reg[2]) begin
				scl_f_reg <= scl_s_reg[2];
			end
			if (sda_s_reg[1] == sda_s_reg[2]) begin
				sda_f_reg <= sda_s_reg[2];
			end
			scl_p_reg <= scl_f_reg;
			sda_p_reg <= sda_f_reg;
		end
	end

	// ----------------------------------------------------------------------
	// Transfer engine
	// ----------------------------------------------------------------------
	// Bits are sampled on clock rise and driven on clock fall. At 25 MHz a
	// 400 kHz bus gives about 30 samples per half period, ample margin.
	always @(posedge mclk_i) begin
		if (!rst_b_i) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 4'h0;
			sh_reg <= 8'h00;
			tx_reg <= 8'h00;
			ptr_reg <= 2'h0;
			rw_reg <= 1'b0;
			first_reg <= 1'b0;
			nack_reg <= 1'b0;
			sda_oe_o <= 1'b0;
			clr_int_o <= 1'b0;
		end else if (ce_i) begin
			clr_int_o <= 1'b0;
			if (start_c) begin
				// A start, repeated or not, always begins an address byte.
				state_reg <= ST_ADDR;
				cnt_reg <= 4'h0;
				sda_oe_o <= 1'b0;
			end else if (stop_c) begin
				state_reg <= ST_IDLE;
				sda_oe_o <= 1'b0;
			end else begin
				case (state_reg)
					ST_ADDR, ST_WR: begin
						if (scl_rise && cnt_reg != 4'h8) begin
							sh_reg <= {sh_reg[6:0], sda_f_reg};
							cnt_reg <= cnt_reg + 4'h1;
						end else if (scl_fall && cnt_reg == 4'h8) begin
							if (state_reg == ST_ADDR) begin
								// Only the strapped address is acknowledged.
								if (sh_reg[7:1] == my_addr) begin
									rw_reg <= sh_reg[0];
									first_reg <= 1'b1;
									sda_oe_o <= 1'b1;
									state_reg <= ST_ACK;
								end else begin
									state_reg <= ST_IDLE;
								end
							end else begin
								// First byte sets the pointer and may carry the clear.
								if (first_reg) begin
									ptr_reg <= sh_reg[1:0];
									clr_int_o <= sh_reg[`PMC_CMD_CLR_BIT];
									first_reg <= 1'b0;
								end
								sda_oe_o <= 1'b1;
								state_reg <= ST_ACK;
							end
						end
					end
					ST_ACK: begin
						if (scl_fall) begin
							cnt_reg <= 4'h0;
							if (rw_reg) begin
								tx_reg <= rd_byte;
								sda_oe_o <= ~rd_byte[7];
								ptr_reg <= ptr_reg + 2'h1;
								state_reg <= ST_RD;
							end else begin
								sda_oe_o <= 1'b0;
								state_reg <= ST_WR;
							end
						end
					end
					ST_RD: begin
						if (scl_rise) begin
							cnt_reg <= cnt_reg + 4'h1;
						end else if (scl_fall) begin
							if (cnt_reg == 4'h8) begin
								sda_oe_o <= 1'b0;
								state_reg <= ST_RACK;
							end else begin
								tx_reg <= {tx_reg[6:0], 1'b0};
								sda_oe_o <= ~tx_reg[6];
							end
						end
					end
					ST_RACK: begin
						if (scl_rise) begin
							nack_reg <= sda_f_reg;
						end else if (scl_fall) begin
							// A declined byte ends the read; the line stays released.
							if (nack_reg) begin
								state_reg <= ST_IDLE;
							end else begin
								cnt_reg <= 4'h0;
								tx_reg <= rd_byte;
								sda_oe_o <= ~rd_byte[7];
								ptr_reg <= ptr_reg + 2'h1;
								state_reg <= ST_RD;
							end
						end
					end
					default: begin
						sda_oe_o <= 1'b0;
					end
				endcase
			end
		end
	end

endmodule

// [verilog/pmc_prox_ctrl.v]
// Proximity measurement sequencer with offset, saturation, thresholds and alert pin.
`timescale 1ns/100ps
`include "pmc_regs.vh"

module pmc_prox_ctrl #(
	parameter PULSE_CYC = `PMC_PULSE_CYC,
	parameter WAIT_STEP_CYC = `PMC_WAIT_STEP_CYC,
	parameter DATA_W = 16
) (
	// Clock, reset and enable.
	input wire mclk_i,
	input wire rst_b_i,
	input wire ce_i,
	// Configuration bits.
	input wire enable_i,
	input wire wait_en_i,
	input wire wait_long_i,
	input wire [7:0] wait_time_i,
	input wire [7:0] pulse_count_i,
	input wire ir_channel_i,
	input wire [DATA_W-1:0] offset_i,
	input wire int_en_i,
	input wire [DATA_W-1:0] thr_low_i,
	input wire [DATA_W-1:0] thr_high_i,
	input wire [3:0] persist_i,
	input wire sleep_after_int_i,
	input wire addr_alt_i,
	// Converter handshake on the same clock.
	input wire adc_done_i,
	input wire [DATA_W-1:0] adc_data_i,
	input wire adc_sat_i,
	output reg adc_start_o,
	output reg broadband_diode_channel_o,
	output reg infrared_diode_channel_o,
	// Emitter sink pin, open drain.
	output reg emitter_sink_pin_o,
	output reg emitter_sink_pin_oe_o,
	// Alert pin, open drain, active low.
	output reg alert_n_o,
	output reg alert_n_oe_o,
	// Serial bus pins.
	input wire scl_i,
	input wire sda_i,
	output reg sda_o,
	output wire sda_oe_o,
	// Visible state.
	output reg [DATA_W-1:0] prox_data_o,
	output reg sat_o,
	output reg int_o,
	output reg sleeping_o
);

	localparam ST_IDLE = 3'd0;
	localparam ST_WAIT = 3'd1;
	localparam ST_PON = 3'd2;
	localparam ST_POFF = 3'd3;
	localparam ST_CONV = 3'd4;
	localparam ST_EVAL = 3'd5;
	localparam ST_SLEEP = 3'd6;
	// Counts are worked out at full width and then cut on purpose to the timer and step widths.
	localparam [31:0] PULSE_LAST_W = PULSE_CYC - 1;
	localparam [31:0] STEP_LAST_W = WAIT_STEP_CYC - 1;
	localparam [31:0] LONG_MULT_W = `PMC_WAIT_LONG_MULT;
	localparam [23:0] PULSE_LAST = PULSE_LAST_W[23:0];
	localparam [23:0] STEP_LAST = STEP_LAST_W[23:0];
	localparam [11:0] LONG_MULT = LONG_MULT_W[11:0];

	reg [2:0] state_reg; // Measurement sequencer state.
	reg [23:0] tmr_reg; // Cycle timer within a pulse, gap or wait step.
	reg [11:0] step_reg; // Remaining wait steps.
	reg [7:0] pulses_reg; // Remaining emitter pulses.
	reg [3:0] pers_reg; // Consecutive out-of-range count.
	reg [DATA_W-1:0] corr_next; // Offset-corrected conversion result.
	wire clr_int; // One-cycle clear from the serial port.
	wire out_of_range = (prox_data_o > thr_high_i) || (prox_data_o < thr_low_i);
	wire [11:0] wait_steps = wait_long_i ?
		(({4'h0, wait_time_i} + 12'h001) * LONG_MULT) : ({4'h0, wait_time_i} + 12'h001);

	// ----------------------------------------------------------------------
	// Offset correction
	// ----------------------------------------------------------------------
	// Crosstalk offset is subtracted and floored at zero; wrapping would turn
	// a dark reading into a false near object.
	always @* begin
		if (adc_data_i > offset_i) begin
			corr_next = adc_data_i - offset_i;
		end else begin
			corr_next = {DATA_W{1'b0}};
		end
	end

	// ----------------------------------------------------------------------
	// Serial target
	// ----------------------------------------------------------------------
	pmc_i2c_target u_i2c (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.ce_i(ce_i),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.sda_oe_o(sda_oe_o),
		.addr_alt_i(addr_alt_i),
		.data_i(prox_data_o),
		.sat_i(sat_o),
		.int_i(int_o),
		.persist_cnt_i(pers_reg),
		.clr_int_o(clr_int)
	);

	// ----------------------------------------------------------------------
	// Measurement sequencer
	// ----------------------------------------------------------------------
	// One process owns the cycle so that the data, flag and alert updates
	// can never interleave with a half-finished measurement.
	always @(posedge mclk_i) begin
		if (!rst_b_i) begin
			state_reg <= ST_IDLE;
			tmr_reg <= 24'h000000;
			step_reg <= 12'h000;
			pulses_reg <= 8'h00;
			pers_reg <= 4'h0;
			adc_start_o <= 1'b0;
			broadband_diode_channel_o <= 1'b0;
			infrared_diode_channel_o <= 1'b0;
			emitter_sink_pin_o <= 1'b0;
			emitter_sink_pin_oe_o <= 1'b0;
			alert_n_o <= 1'b0;
			alert_n_oe_o <= 1'b0;
			sda_o <= 1'b0;
			prox_data_o <= {DATA_W{1'b0}};
			sat_o <= 1'b0;
			int_o <= 1'b0;
			sleeping_o <= 1'b0;
		end else if (ce_i) begin
			adc_start_o <= 1'b0;
			// Clear from firmware drops the flag unless set in the same cycle.
			if (clr_int) begin
				int_o <= 1'b0;
			end
			// The alert pin mirrors the sticky flag as a level.
			alert_n_oe_o <= int_o;
			case (state_reg)
				ST_IDLE: begin
					sleeping_o <= 1'b0;
					if (enable_i) begin
						// Select exactly one diode for the whole cycle.
						broadband_diode_channel_o <= ~ir_channel_i;
						infrared_diode_channel_o <= ir_channel_i;
						// Zero is treated as one pulse.
						pulses_reg <= (pulse_count_i == 8'h00) ? 8'h01 : pulse_count_i;
						tmr_reg <= 24'h000000;
						step_reg <= wait_steps;
						if (wait_en_i) begin
							state_reg <= ST_WAIT;
						end else begin
							emitter_sink_pin_oe_o <= 1'b1;
							state_reg <= ST_PON;
						end
					end
				end
				ST_WAIT: begin
					// Steps of 2.7 ms, up to 256 or 3072 steps.
					if (tmr_reg == STEP_LAST) begin
						tmr_reg <= 24'h000000;
						if (step_reg == 12'h001) begin
							emitter_sink_pin_oe_o <= 1'b1;
							state_reg <= ST_PON;
						end else begin
							step_reg <= step_reg - 12'h001;
						end
					end else begin
						tmr_reg <= tmr_reg + 24'h000001;
					end
				end
				ST_PON: begin
					// Sink held for exactly PULSE_CYC cycles.
					if (tmr_reg == PULSE_LAST) begin
						tmr_reg <= 24'h000000;
						emitter_sink_pin_oe_o <= 1'b0;
						pulses_reg <= pulses_reg - 8'h01;
						state_reg <= ST_POFF;
					end else begin
						tmr_reg <= tmr_reg + 24'h000001;
					end
				end
				ST_POFF: begin
					// Equal-length gap between pulses, then the next or conversion.
					if (tmr_reg == PULSE_LAST) begin
						tmr_reg <= 24'h000000;
						if (pulses_reg == 8'h00) begin
							adc_start_o <= 1'b1;
							state_reg <= ST_CONV;
						end else begin
							emitter_sink_pin_oe_o <= 1'b1;
							state_reg <= ST_PON;
						end
					end else begin
						tmr_reg <= tmr_reg + 24'h000001;
					end
				end
				ST_CONV: begin
					if (adc_done_i) begin
						prox_data_o <= corr_next;
						sat_o <= adc_sat_i;
						state_reg <= ST_EVAL;
					end
				end
				ST_EVAL: begin
					if (int_en_i && out_of_range) begin
						if (pers_reg >= persist_i) begin
							int_o <= 1'b1;
							if (sleep_after_int_i) begin
								sleeping_o <= 1'b1;
								state_reg <= ST_SLEEP;
							end else begin
								state_reg <= ST_IDLE;
							end
						end else begin
							pers_reg <= pers_reg + 4'h1;
							state_reg <= ST_IDLE;
						end
					end else begin
						pers_reg <= 4'h0;
						state_reg <= ST_IDLE;
					end
				end
				ST_SLEEP: begin
					// Sleep ends only once firmware has released the alert.
					if (!int_o) begin
						sleeping_o <= 1'b0;
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

endmodule

// [sim/pmc_prox_ctrl_monitor.sv]
// Checker bound to the proximity controller top; it watches the top's ports only.
`timescale 1ns/100ps

module pmc_prox_ctrl_monitor #(
	parameter PULSE_CYC = 175
) (
	// Clock and reset.
	input wire mclk_i,
	input wire rst_b_i,
	// Inputs that cause the watched outputs.
	input wire ir_channel_i,
	input wire [15:0] offset_i,
	input wire adc_done_i,
	input wire [15:0] adc_data_i,
	input wire adc_sat_i,
	input wire scl_i,
	input wire sda_i,
	// Watched outputs.
	input wire adc_start_o,
	input wire broadband_diode_channel_o,
	input wire infrared_diode_channel_o,
	input wire emitter_sink_pin_oe_o,
	input wire alert_n_oe_o,
	input wire [15:0] prox_data_o,
	input wire sat_o,
	input wire int_o,
	input wire sleeping_o
);
	// ------
	// Helper logic
	// ------
	// Clocks the emitter sink has been on; a repetition count could not reach 175.
	integer oe_len;
	always @(posedge mclk_i) begin
		if (!rst_b_i || !emitter_sink_pin_oe_o) begin
			oe_len <= 0;
		end else begin
			oe_len <= oe_len + 1;
		end
	end

	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);

	// ------
	// Properties
	// ------
	a_pulse_width: assert property ($fell(emitter_sink_pin_oe_o) |-> oe_len == PULSE_CYC)
		else $error("emitter pulse length wrong");
	a_result_load: assert property (adc_done_i |=> prox_data_o == (($past(adc_data_i) >
		$past(offset_i)) ? $past(adc_data_i) - $past(offset_i) : 16'h0))
		else $error("corrected result wrong");
	a_sat_load: assert property (adc_done_i |=> sat_o == $past(adc_sat_i))
		else $error("saturation flag wrong");
	a_result_hold: assert property (!adc_done_i |=> $stable(prox_data_o) && $stable(sat_o))
		else $error("result changed without conversion");
	a_alert_level: assert property (1'b1 |=> alert_n_oe_o == $past(int_o))
		else $error("alert pin does not follow flag");
	a_alert_hold: assert property ((int_o && scl_i && sda_i) [*8] |=> int_o)
		else $error("interrupt dropped on idle bus");
	a_int_cause: assert property ($rose(int_o) |-> $past(adc_done_i, 2))
		else $error("interrupt without result");
	a_start_single: assert property (adc_start_o |-> !emitter_sink_pin_oe_o ##1 !adc_start_o)
		else $error("conversion start misplaced");
	a_channel_sel: assert property (adc_start_o |-> infrared_diode_channel_o == ir_channel_i
		&& broadband_diode_channel_o != ir_channel_i) else $error("wrong diode channel");
	a_sleep_quiet: assert property (sleeping_o && $stable(sleeping_o) |->
		!emitter_sink_pin_oe_o && !adc_start_o) else $error("activity while asleep");
endmodule

bind pmc_prox_ctrl pmc_prox_ctrl_monitor #(.PULSE_CYC(PULSE_CYC)) u_mon (.mclk_i, .rst_b_i,
	.ir_channel_i, .offset_i, .adc_done_i, .adc_data_i, .adc_sat_i, .scl_i, .sda_i, .adc_start_o,
	.broadband_diode_channel_o, .infrared_diode_channel_o, .emitter_sink_pin_oe_o, .alert_n_oe_o,
	.prox_data_o, .sat_o, .int_o, .sleeping_o);

// [sim/pmc_i2c_host.sv]
// Behavioural two-wire bus controller: drives the clock, only ever pulls data low.
`timescale 1ns/100ps

module pmc_i2c_host (
	// Bus pins.
	output logic scl_o,
	output logic sda_oe_o,
	input wire logic sda_i
);
	// Low and high times, 320 ns per bit; the long low leaves room for the target's hold.
	int tl = 220;
	int th = 100;
	initial begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end
	// Start or repeated start: data falls while the clock is high.
	// The full low time lets the target let go of its acknowledge first.
	task start();
		sda_oe_o = 1'b0;
		#tl;
		scl_o = 1'b1;
		#th;
		sda_oe_o = 1'b1;
		#th;
		scl_o = 1'b0;
	endtask
	// One bit: data set mid low, sampled just before the clock falls.
	task bit_io(input logic b, output logic r);
		#(tl / 2);
		sda_oe_o = !b;
		#(tl - tl / 2);
		scl_o = 1'b1;
		#th;
		r = sda_i;
		scl_o = 1'b0;
	endtask
	// A byte plus its acknowledge slot; nak high releases the line there.
	task xfer(input logic [7:0] d, input logic nak, output logic [7:0] r, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
		bit_io(nak, a);
		ack = !a;
	endtask
	// Stop: data rises while the clock is high.
	task stop();
		#(tl / 2);
		sda_oe_o = 1'b1;
		#(tl - tl / 2);
		scl_o = 1'b1;
		#th;
		sda_oe_o = 1'b0;
		#tl;
	endtask
endmodule

// [sim/pmc_prox_ctrl_tb_top.sv]
// Self-checking bench: converter model, bus host and result model around the controller.
`timescale 1ns/100ps
`include "pmc_regs.vh"

module pmc_prox_ctrl_tb_top;
	// Short pulse and wait steps keep the run brief.
	localparam PCYC = 10;
	localparam WCYC = 20;
	logic mclk_i, rst_b_i, enable_i, wait_en_i, wait_long_i, ir_channel_i, int_en_i, ce_i;
	logic sleep_after_int_i, addr_alt_i, adc_done_i, adc_sat_i, out, sat_e, led_q, exp_int;
	logic [7:0] wait_time_i, pulse_count_i;
	logic [3:0] persist_i;
	logic [15:0] offset_i, thr_low_i, thr_high_i, adc_data_i, exp, d;
	wire adc_start_o, broadband_diode_channel_o, infrared_diode_channel_o, emitter_sink_pin_oe_o;
	wire alert_n_oe_o, sda_oe_o, sat_o, int_o, sleeping_o, scl_i, host_oe;
	wire [15:0] prox_data_o;
	// Pulled-up data line, low while either side pulls.
	wire sda_i = !(sda_oe_o || host_oe);
	int failures, check_count, seed, left, pulses, since_done, cnt, starts, raw, gap, n;
	int raw_q[$];

	pmc_prox_ctrl #(.PULSE_CYC(PCYC), .WAIT_STEP_CYC(WCYC)) uut (.mclk_i, .rst_b_i, .ce_i,
		.enable_i, .wait_en_i, .wait_long_i, .wait_time_i, .pulse_count_i, .ir_channel_i,
		.offset_i, .int_en_i, .thr_low_i, .thr_high_i, .persist_i, .sleep_after_int_i, .addr_alt_i,
		.adc_done_i, .adc_data_i, .adc_sat_i, .adc_start_o, .broadband_diode_channel_o,
		.infrared_diode_channel_o, .emitter_sink_pin_o(), .emitter_sink_pin_oe_o, .alert_n_o(),
		.alert_n_oe_o, .scl_i, .sda_i, .sda_o(), .sda_oe_o, .prox_data_o, .sat_o, .int_o,
		.sleeping_o);
	pmc_i2c_host h (.scl_o(scl_i), .sda_oe_o(host_oe), .sda_i(sda_i));

	initial begin
		mclk_i = 1'b0;
		forever #20 mclk_i = ~mclk_i;
	end

	// ------
	// Checking and closing
	// ------
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	task stop_test();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Bounded wait for the converter model to use up its quota of results.
	task wait_left();
		for (int i = 0; i < 20000 && left > 0; i++) @(negedge mclk_i);
		if (left > 0) begin
			failures++;
			stop_test();
		end
		repeat (4) @(negedge mclk_i);
	endtask
	task run(input int k);
		since_done = 100000;
		left = k;
		enable_i = 1'b1;
		wait_left();
	endtask
	// Bus access: address byte, one written byte, then two bytes read back if asked.
	task acc(input [6:0] a, input [7:0] w, input logic rd, input logic ak_e);
		logic [7:0] r0, r1;
		logic k;
		r1 = 8'h00;
		h.start();
		h.xfer({a, 1'b0}, 1'b1, r0, k);
		chk("addr_ack", k, ak_e);
		if (k) begin
			h.xfer(w, 1'b1, r0, k);
			if (rd) begin
				h.start();
				h.xfer({a, 1'b1}, 1'b1, r0, k);
				h.xfer(8'hff, 1'b0, r0, k);
				h.xfer(8'hff, 1'b1, r1, k);
			end
		end
		h.stop();
		d = {r1, r0};
		// Later stimulus goes back onto the falling edge.
		@(negedge mclk_i);
	endtask

	// ------
	// Converter and result model
	// ------
	// Answers each start; the stored result, flag and interrupt are then compared.
	initial forever begin
		@(posedge mclk_i);
		#1;
		if (adc_start_o === 1'b1) begin
			repeat (3) @(negedge mclk_i);
			raw = (raw_q.size() > 0) ? raw_q.pop_front() : $random(seed);
			adc_data_i = raw[15:0];
			adc_sat_i = raw[16];
			adc_done_i = 1'b1;
			@(negedge mclk_i);
			adc_done_i = 1'b0;
			sat_e = adc_sat_i;
			since_done = 0;
			exp = (adc_data_i > offset_i) ? adc_data_i - offset_i : 16'h0;
			out = exp > thr_high_i || exp < thr_low_i;
			cnt = (int_en_i && out) ? cnt + 1 : 0;
			if (cnt > persist_i) exp_int = 1'b1;
			if (left > 0) left--;
			if (left == 0) enable_i = 1'b0;
			@(posedge mclk_i);
			#1;
			chk("prox_data", prox_data_o, exp);
			chk("sat", sat_o, sat_e);
			@(posedge mclk_i);
			#1;
			chk("int", int_o, exp_int);
		end
	end
	// Pulse count and channel checked as each conversion starts; wait gap checked at the first pulse.
	always @(posedge mclk_i) begin
		#1;
		since_done++;
		if (emitter_sink_pin_oe_o && !led_q) begin
			if (pulses == 0 && wait_en_i && since_done < 5000) begin
				chk("wait_gap", since_done >= gap && since_done <= gap + 4, 1);
			end
			pulses++;
		end
		if (adc_start_o) begin
			chk("pulses", pulses, pulse_count_i == 0 ? 1 : pulse_count_i);
			chk("channel", {infrared_diode_channel_o, broadband_diode_channel_o},
				{ir_channel_i, !ir_channel_i});
			pulses = 0;
			starts++;
		end
		led_q = emitter_sink_pin_oe_o;
	end

	// ------
	// Main sequence
	// ------
	initial begin
		seed = 32'hcb71;
		ce_i = 1'b1;
		{rst_b_i, enable_i, wait_en_i, wait_long_i, ir_channel_i, int_en_i} = 6'h0;
		{sleep_after_int_i, addr_alt_i, adc_done_i, adc_sat_i, led_q, exp_int} = 6'h0;
		{wait_time_i, persist_i, offset_i, thr_low_i, adc_data_i} = 60'h0;
		thr_high_i = 16'hffff;
		pulse_count_i = 8'h01;
		repeat (16) @(negedge mclk_i);
		rst_b_i = 1'b1;
		// Pulse counts 0, 1, 2, 255, 4, 5 on alternating channels with random offsets.
		for (int i = 0; i < 6; i++) begin
			pulse_count_i = (i == 3) ? 8'hff : i[7:0];
			ir_channel_i = i[0];
			offset_i = 16'($random(seed)) >> 4;
			run(1);
		end
		acc(`PMC_ADDR_MAIN, {6'h0, `PMC_IDX_DATA_LO}, 1'b1, 1'b1);
		chk("bus_data", d, exp);
		acc(`PMC_ADDR_ALT, 8'h00, 1'b0, 1'b0);
		// Two out, one in, three out: only the sixth result may raise the alert.
		{int_en_i, persist_i, thr_low_i, thr_high_i, offset_i} = {5'h12, 48'h0100_1000_0000};
		pulse_count_i = 8'h01;
		raw_q = '{32'h2000, 32'h0050, 32'h0500, 32'h3000, 32'h2000, 32'h0040};
		run(6);
		chk("alert", alert_n_oe_o, 1'b1);
		// Pointer 3 wraps to 0: persistence count held at its threshold, then status.
		acc(`PMC_ADDR_MAIN, {6'h0, `PMC_IDX_PERSIST}, 1'b1, 1'b1);
		chk("persist_cnt", d[7:0], {4'h0, persist_i});
		chk("status", d[9:8], 2'b10);
		exp_int = 1'b0;
		acc(`PMC_ADDR_MAIN, 8'h80, 1'b0, 1'b1);
		chk("int_clear", int_o, 1'b0);
		// Wait of three steps short and thirty-six steps long.
		{int_en_i, wait_en_i, wait_time_i} = 10'h102;
		for (int i = 0; i < 2; i++) begin
			wait_long_i = i[0];
			gap = 3 * (wait_long_i ? 12 : 1) * WCYC;
			run(2);
		end
		wait_en_i = 1'b0;
		// Sleep after interrupt, then wake on clear.
		{int_en_i, persist_i, sleep_after_int_i} = 6'h21;
		raw_q = '{32'h5000, 32'h0500};
		run(1);
		n = starts;
		enable_i = 1'b1;
		repeat (300) @(negedge mclk_i);
		chk("asleep", {sleeping_o, starts == n}, 2'b11);
		left = 1;
		exp_int = 1'b0;
		acc(`PMC_ADDR_MAIN, 8'h80, 1'b0, 1'b1);
		wait_left();
		chk("awake", {sleeping_o, starts == n + 1}, 2'b01);
		// Clock enable low freezes the sequencer even while it is enabled.
		ce_i = 1'b0;
		enable_i = 1'b1;
		repeat (50) @(negedge mclk_i);
		chk("freeze", {emitter_sink_pin_oe_o, starts == n + 1}, 2'b01);
		{ce_i, enable_i} = 2'b10;
		// Second reset with the alternate address strap.
		rst_b_i = 1'b0;
		addr_alt_i = 1'b1;
		repeat (16) @(negedge mclk_i);
		rst_b_i = 1'b1;
		acc(`PMC_ADDR_ALT, {6'h0, `PMC_IDX_DATA_LO}, 1'b1, 1'b1);
		chk("alt_data", d, 16'h0);
		acc(`PMC_ADDR_MAIN, 8'h00, 1'b0, 1'b0);
		stop_test();
	end
endmodule
